// >>> design/mxio_pkg.sv
// Purpose: Shared constants and types of the multiplexed eight-bit port.
// Assumes: AHB-Lite register access, one aligned word per register.
// Notes:   Register indices are kept; byte address is four times the index.

package mxio_pkg;

   // ************************************************
   // Sizes and register map
   // ************************************************
   localparam int          PORT_W        = 8;
   localparam int          SYNC_STAGES   = 2;
   localparam logic [31:0] DIR_INDEX     = 32'h0000ffb5;
   localparam logic [31:0] DATA_INDEX    = 32'h0000ffb7;
   localparam logic [31:0] DIR_ADDR      = DIR_INDEX << 2;
   localparam logic [31:0] DATA_ADDR     = DATA_INDEX << 2;
   localparam logic [7:0]  DIR_RESET     = 8'h00;
   localparam logic [7:0]  DATA_RESET    = 8'h00;
   localparam logic [7:0]  DIR_READ_BACK = 8'hff;
   localparam logic [31:0] WORD_ZERO     = 32'h00000000;
   localparam logic [23:0] UPPER_ZERO    = 24'h000000;

   // ************************************************
   // Bus encodings
   // ************************************************
   localparam logic [2:0]  HSIZE_WORD    = 3'h2;
   localparam logic        HRESP_OKAY    = 1'h0;

   // ************************************************
   // Pin positions of the shared functions
   // ************************************************
   localparam int          PIN_TCI0      = 0;
   localparam int          PIN_TRI0      = 1;
   localparam int          PIN_CMP0      = 2;
   localparam int          PIN_TCI1      = 3;
   localparam int          PIN_TRI1      = 4;
   localparam int          PIN_CMP1      = 5;
   localparam int          PIN_FRC_A     = 6;
   localparam int          PIN_FRC_B     = 7;

   // ************************************************
   // Types
   // ************************************************
   typedef enum logic [2:0] {
      MXIO_IDLE  = 3'h1,
      MXIO_WRITE = 3'h2,
      MXIO_READ  = 3'h4
   } mxio_phase_e;

   typedef struct packed {
      logic cmp0;
      logic cmp0_en;
      logic cmp1;
      logic cmp1_en;
      logic frc_a;
      logic frc_a_en;
      logic frc_b;
   } mxio_periph_s;

   typedef struct packed {
      logic [7:0] data;
      logic       oe;
   } mxio_ram_s;

endpackage : mxio_pkg

// >>> design/mxio_port.sv
// Purpose: Eight-bit general-purpose port with shared timer and RAM functions.
// Assumes: Standby and mode levels come from logic on hclk.
// Notes:   Pin drive is registered, so a change reaches the pins one cycle later.
//
// How it works
// (RL1) Direction bit 1 drives the pin, direction bit 0 makes it an input.
// (RL2) Direction register is write-only and reads back as all ones.
// (RL3) Reset and hardware standby clear direction to zero, all pins input.
// (RL4) Software standby keeps direction, so output pins keep driving.
// (RL5) Software standby drops peripheral use; pins revert to plain port control.
// (RL6) Reading an output pin returns the stored data bit.
// (RL7) Reading an input pin returns the synchronised pin level.
// (RL8) The same read-back selection applies to pins used by peripherals.
// (RL9) Data register is read/write, cleared by resets, kept in software standby.
// (RL10) Expanded modes share pins with RAM bus, timer inputs and compare outputs.
// (RL11) Eight pins, each with own direction and data bit at 7 to 0.
// (RL12) Top pin chosen by slave enable, compare-B enable and its direction bit.
// (RL13) An enabled peripheral output overrides the data register on its pin.

`timescale 1ns/1ps
`default_nettype none

module mxio_port
   import mxio_pkg::*;
#(
   parameter int WIDTH = mxio_pkg::PORT_W
) (
   // Clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // AHB-Lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic      [31:0]            hrdata,
   // Operating modes
   input  wire logic                   expanded_mode,
   input  wire logic                   slave_port_mode_enable,
   input  wire logic                   compare_b_output_enable,
   input  wire logic                   hw_standby,
   input  wire logic                   sw_standby,
   // Peripheral side
   input  wire mxio_pkg::mxio_periph_s periph,
   input  wire mxio_pkg::mxio_ram_s    ram,
   output logic      [1:0]             timer_reset_input,
   output logic      [1:0]             timer_clock_input,
   output logic      [7:0]             shared_ram_data_line,
   // Pins
   input  wire logic [WIDTH-1:0]       pin_in,
   output logic      [WIDTH-1:0]       pin_out,
   output logic      [WIDTH-1:0]       pin_oe_n
);

   import mxio_pkg::*;

   // The per-pin function map is fixed to eight positions, so other widths are refused.
   if (WIDTH != PORT_W) begin : g_width_check
      $error("mxio_port serves exactly eight pins.");
   end

   // ************************************************
   // Register state
   // ************************************************
   logic [7:0] dir_q;
   logic [7:0] dir_d;
   logic [7:0] data_q;
   logic [7:0] data_d;
   logic       wr_phase;

   // ************************************************
   // Functions
   // ************************************************
   function automatic logic hits(input logic [31:0] addr,
                                 input logic [31:0] reg_addr);
      hits = (addr == reg_addr);
   endfunction : hits

   // Output pins read their stored bit, input pins their synchronised level.
   function automatic logic [7:0] read_back(input logic [7:0] dir,
                                            input logic [7:0] dat,
                                            input logic [7:0] pin);
      read_back = (dir & dat) | (~dir & pin);
   endfunction : read_back

   // ************************************************
   // Pin synchroniser
   // ************************************************
   logic [7:0] pin_sync;

   mxio_sync #(
      .W      (WIDTH),
      .STAGES (SYNC_STAGES)
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // ************************************************
   // Bus phase tracking
   // ************************************************
   mxio_phase_e phase_q;
   mxio_phase_e phase_d;
   logic        sel_dir_q;
   logic        sel_dir_d;
   logic        sel_data_q;
   logic        sel_data_d;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic        addr_valid;
   logic [31:0] rd_word;

   assign addr_valid = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);

   always_comb begin
      rd_word = WORD_ZERO;
      if (hits(haddr, DIR_ADDR)) begin
         rd_word = {UPPER_ZERO, DIR_READ_BACK}; // RL2
      end else if (hits(haddr, DATA_ADDR)) begin
         rd_word = {UPPER_ZERO, read_back(dir_q, data_q, pin_sync)}; // RL6 RL7 RL8
      end
   end

   always_comb begin
      phase_d    = MXIO_IDLE;
      sel_dir_d  = 1'b0;
      sel_data_d = 1'b0;
      hrdata_d   = WORD_ZERO;
      if (addr_valid) begin
         sel_dir_d  = hits(haddr, DIR_ADDR);
         sel_data_d = hits(haddr, DATA_ADDR);
         if (hwrite) begin
            phase_d = MXIO_WRITE;
         end else begin
            phase_d  = MXIO_READ;
            hrdata_d = rd_word;
         end
      end else if (!hready) begin
         phase_d    = phase_q;
         sel_dir_d  = sel_dir_q;
         sel_data_d = sel_data_q;
         hrdata_d   = hrdata_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_q    <= MXIO_IDLE;
         sel_dir_q  <= 1'b0;
         sel_data_q <= 1'b0;
         hrdata_q   <= WORD_ZERO;
      end else begin
         phase_q    <= phase_d;
         sel_dir_q  <= sel_dir_d;
         sel_data_q <= sel_data_d;
         hrdata_q   <= hrdata_d;
      end
   end

   // ************************************************
   // Bus response
   // ************************************************
   // Zero wait states, so the read data register is already valid in the data phase.
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
   assign hrdata    = hrdata_q;

   // ************************************************
   // Direction and data registers
   // ************************************************
   // Only a completed write address phase opens the data phase for a register update.
   always_comb begin
      case (phase_q)
         MXIO_IDLE: begin
            wr_phase = 1'b0;
         end
         MXIO_WRITE: begin
            wr_phase = 1'b1;
         end
         MXIO_READ: begin
            wr_phase = 1'b0;
         end
         default: begin
            wr_phase = 1'b0;
         end
      endcase
   end

   // Software standby leaves both registers alone, so output pins keep their level.
   // Hardware standby clears them synchronously; a write in that same cycle is lost.
   always_comb begin
      dir_d  = dir_q; // RL4
      data_d = data_q; // RL9
      if (hw_standby) begin
         dir_d  = DIR_RESET; // RL3
         data_d = DATA_RESET; // RL9
      end else if (wr_phase) begin
         if (sel_dir_q) begin
            dir_d = hwdata[7:0]; // RL11
         end
         if (sel_data_q) begin
            data_d = hwdata[7:0]; // RL9 RL11
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_q  <= DIR_RESET; // RL3
         data_q <= DATA_RESET; // RL9
      end else begin
         dir_q  <= dir_d;
         data_q <= data_d;
      end
   end

   // ************************************************
   // Pin function selection
   // ************************************************
   logic [7:0] per_en;
   logic [7:0] per_val;
   logic [7:0] drv_en;
   logic [7:0] drv_val;
   logic       standby_any;
   logic       shared_ok;
   logic [7:0] pin_out_q;
   logic [7:0] pin_out_d;
   logic [7:0] pin_oe_n_q;
   logic [7:0] pin_oe_n_d;

   // Shared use is dropped in either standby, so peripheral outputs no longer reach the pins.
   assign standby_any = sw_standby || hw_standby;
   assign shared_ok   = expanded_mode && !standby_any; // RL5 RL10

   always_comb begin
      per_en             = 8'h00;
      per_val            = 8'h00;
      per_en[PIN_CMP0]   = periph.cmp0_en;
      per_val[PIN_CMP0]  = periph.cmp0;
      per_en[PIN_CMP1]   = periph.cmp1_en;
      per_val[PIN_CMP1]  = periph.cmp1;
      per_en[PIN_FRC_A]  = periph.frc_a_en;
      per_val[PIN_FRC_A] = periph.frc_a;
      // The top pin has no enable of its own; the compare-B enable stands in for it.
      per_en[PIN_FRC_B]  = compare_b_output_enable; // RL12
      per_val[PIN_FRC_B] = periph.frc_b;
   end

   always_comb begin
      drv_en  = dir_q; // RL1
      drv_val = data_q; // RL1
      if (shared_ok) begin
         if (slave_port_mode_enable) begin
            drv_en  = {WIDTH{ram.oe}}; // RL10 RL12
            drv_val = ram.data; // RL10
         end else begin
            for (int i = 0; i < WIDTH; i++) begin
               if (per_en[i]) begin
                  drv_en[i]  = 1'b1; // RL13
                  drv_val[i] = per_val[i]; // RL13
               end
            end
         end
      end
      pin_out_d  = drv_val & drv_en;
      pin_oe_n_d = ~drv_en;
   end

   // ************************************************
   // Pin drive registers
   // ************************************************
   // Registering the drive keeps decode glitches off the pins, at one cycle of lag.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out_q  <= 8'h00;
         pin_oe_n_q <= 8'hff;
      end else begin
         pin_out_q  <= pin_out_d;
         pin_oe_n_q <= pin_oe_n_d;
      end
   end

   assign pin_out  = pin_out_q;
   assign pin_oe_n = pin_oe_n_q;

   // ************************************************
   // Inputs handed to the timers and the RAM bus
   // ************************************************
   // Timer inputs see the pin at all times; the timer itself decides whether to use it.
   assign timer_clock_input    = {pin_sync[PIN_TCI1], pin_sync[PIN_TCI0]}; // RL10
   assign timer_reset_input    = {pin_sync[PIN_TRI1], pin_sync[PIN_TRI0]}; // RL10
   assign shared_ram_data_line = pin_sync; // RL10

endmodule : mxio_port

`default_nettype wire

// >>> design/mxio_sync.sv
// Purpose: Multi-stage synchroniser for pin levels.
// Assumes: Inputs are asynchronous to hclk.
// Notes:   Only the last stage may be read outside this module.

`timescale 1ns/1ps
`default_nettype none

module mxio_sync #(
   parameter int W      = 8,
   parameter int STAGES = 2
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [STAGES-1:0][W-1:0] chain_q;
   logic [STAGES-1:0][W-1:0] chain_d;

   if (STAGES < 2 || W < 1) begin : g_size_check
      $error("mxio_sync needs at least two stages.");
   end

   always_comb begin
      chain_d = {chain_q[STAGES-2:0], async_in};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chain_q <= '0;
      end else begin
         chain_q <= chain_d;
      end
   end

   assign sync_out = chain_q[STAGES-1];

endmodule : mxio_sync

`default_nettype wire

// >>> tb/mxio_pins_model.sv
// Purpose: Board-side model of the eight port pins.
// Assumes: The port wins wherever it drives; the board drives the rest where ext_en is set.
// Notes:   Pins nobody drives flip each cycle, so a stale level cannot pass.
`timescale 1ns/1ps
`default_nettype none
module mxio_pins_model (
   // Clock
   input  wire logic       hclk,
   // Port drive and board drive
   input  wire logic [7:0] pin_out, pin_oe_n, ext_v, ext_en,
   // Resolved levels
   output logic      [7:0] pin_in
);
   logic [7:0] float_q = 8'h55;
   always @(posedge hclk) float_q <= ~float_q;
   // ****************
   // Wire resolution
   // ****************
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_v)
                 | (pin_oe_n & ~ext_en & float_q);
endmodule : mxio_pins_model
`default_nettype wire

// >>> tb/mxio_port_assertions.sv
// Purpose: Bus and pin checks of the eight-bit port.
// Assumes: Bound to mxio_port, which answers with no wait states.
// Notes:   Pin drive lags its cause by one edge.
`timescale 1ns/1ps
`default_nettype none
module mxio_port_assertions
   import mxio_pkg::*;
(
   // Clock, reset and bus
   input wire logic        hclk, hresetn, hsel, hwrite, hready,
   input wire logic [1:0]  htrans,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] haddr, hrdata,
   // Modes
   input wire logic        expanded_mode, slave_port_mode_enable,
   input wire logic        compare_b_output_enable, hw_standby, sw_standby,
   // Peripheral side and pins
   input wire mxio_pkg::mxio_periph_s periph,
   input wire mxio_pkg::mxio_ram_s    ram,
   input wire logic [1:0]  timer_reset_input, timer_clock_input,
   input wire logic [7:0]  shared_ram_data_line, pin_in, pin_out, pin_oe_n
);
   // ****************
   // Properties
   // ****************
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire share = expanded_mode && !hw_standby && !sw_standby;
   wire slv = slave_port_mode_enable;
   sequence s_rd;
      hsel && hready && htrans[1] && !hwrite && hsize == HSIZE_WORD;
   endsequence
   sequence s_calm;
      (share && $stable(pin_in))[*4];
   endsequence
   AST_DIR_ONES: assert property (s_rd ##0 haddr == DIR_ADDR |=> hrdata == 32'h000000ff)
      else $error("direction read not all ones");
   AST_UPPER_ZERO: assert property (s_rd |=> hrdata[31:8] == UPPER_ZERO)
      else $error("read data above bit 7 not zero");
   AST_HW_CLEAR: assert property (hw_standby[*2] |=> pin_oe_n == 8'hff)
      else $error("pins still driven in hardware standby");
   AST_CMP0: assert property (share && !slv && periph.cmp0_en |=> !pin_oe_n[PIN_CMP0]
      && pin_out[PIN_CMP0] == $past(periph.cmp0)) else $error("timer output not on pin 2");
   AST_RAM_OUT: assert property (share && slv && ram.oe |=> pin_oe_n == 8'h00
      && pin_out == $past(ram.data)) else $error("ram data not on pins");
   AST_TOP_PIN: assert property (share && !slv && compare_b_output_enable |=>
      !pin_oe_n[PIN_FRC_B] && pin_out[PIN_FRC_B] == $past(periph.frc_b))
      else $error("compare output not on pin 7");
   AST_TMR_IN: assert property (s_calm |-> timer_clock_input == {pin_in[3], pin_in[0]}
      && timer_reset_input == {pin_in[4], pin_in[1]}) else $error("timer inputs wrong");
   AST_RAM_IN: assert property (s_calm |-> shared_ram_data_line == pin_in)
      else $error("ram data line does not follow pins");
endmodule : mxio_port_assertions
bind mxio_port mxio_port_assertions u_mxio_port_assertions (.hclk, .hresetn, .hsel, .hwrite,
   .hready, .htrans, .hsize, .haddr, .hrdata, .expanded_mode, .slave_port_mode_enable,
   .compare_b_output_enable, .hw_standby, .sw_standby, .periph, .ram, .timer_reset_input,
   .timer_clock_input, .shared_ram_data_line, .pin_in, .pin_out, .pin_oe_n);
`default_nettype wire

// >>> tb/mxio_port_test.sv
// Purpose: Self-checking bench of the eight-bit port.
// Assumes: hready is fed back from hreadyout.
// Notes:   Expected values come from dir_m, data_m, the board levels and the driven periph and ram stimulus.
`timescale 1ns/1ps
`default_nettype none
module mxio_port_test;
   import mxio_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hw_standby = 0, sw_standby = 0;
   logic expanded_mode = 0, slave_port_mode_enable = 0, compare_b_output_enable = 0;
   logic [1:0] htrans = 0, tri_o, tci_o;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic hreadyout, hresp;
   mxio_periph_s periph = '0;
   mxio_ram_s ram = '0;
   logic [7:0] ext_v = 0, pin_in, pin_out, pin_oe_n, ram_o, dir_m, data_m;
   int fail_count = 0, samples_checked = 0, seed = 61, cycles = 0;
   mxio_port u_mxio_port (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .expanded_mode, .slave_port_mode_enable,
      .compare_b_output_enable, .hw_standby, .sw_standby, .periph, .ram,
      .timer_reset_input(tri_o), .timer_clock_input(tci_o), .shared_ram_data_line(ram_o),
      .pin_in, .pin_out, .pin_oe_n);
   mxio_pins_model u_mxio_pins_model (.hclk, .pin_out, .pin_oe_n, .ext_v, .ext_en(8'hff),
      .pin_in);
   // ****************
   // Clock, timeout and tasks
   // ****************
   initial begin
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         give_verdict();
      end
   end
   task give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check
   // The master holds each phase until hready is seen high at an edge.
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, WORD_ZERO);
   endtask : xfer
   task setup(input logic [7:0] d, input logic [7:0] v);
      dir_m = d;
      data_m = v;
      xfer(1, DIR_ADDR, {UPPER_ZERO, d});
      xfer(1, DATA_ADDR, {UPPER_ZERO, v});
      repeat (4) @(posedge hclk);
   endtask : setup
   task rd_check(input logic [7:0] lv);
      xfer(0, DATA_ADDR, WORD_ZERO);
      check("data", rd, {UPPER_ZERO, (dir_m & data_m) | (~dir_m & lv)});
      xfer(0, DIR_ADDR, WORD_ZERO);
      check("dir", rd, {UPPER_ZERO, DIR_READ_BACK});
   endtask : rd_check
   task pin_check;
      check("oe", {UPPER_ZERO, pin_oe_n}, {UPPER_ZERO, ~dir_m});
      check("out", {UPPER_ZERO, pin_out}, {UPPER_ZERO, dir_m & data_m});
   endtask : pin_check
   // ****************
   // Scenarios
   // ****************
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      ext_v <= 8'($random(seed));
      dir_m = DIR_RESET;
      data_m = DATA_RESET;
      repeat (4) @(posedge hclk);
      pin_check();
      rd_check(ext_v);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         ext_v <= 8'($random(seed));
         setup(8'($random(seed)), 8'($random(seed)));
         pin_check();
         rd_check(ext_v);
      end
      xfer(1, DATA_ADDR + 4, 32'h000000ff);
      xfer(0, DATA_ADDR + 4, WORD_ZERO);
      check("unmapped", rd, WORD_ZERO);
      hsize <= 3'h0;
      xfer(1, DATA_ADDR, 32'h000000ff);
      hsize <= HSIZE_WORD;
      rd_check(ext_v);
      $display("test gpio done");
      setup(8'hf0, 8'h5a);
      expanded_mode <= 1;
      periph <= 7'h60;
      repeat (4) @(posedge hclk);
      check("cmp0 pin", {30'h0, pin_out[2], pin_oe_n[2]}, 32'h00000002);
      rd_check(ext_v | 8'h04);
      periph <= 7'h1a;
      repeat (4) @(posedge hclk);
      check("cmp1 frc a", {28'h0, pin_out[6:5], pin_oe_n[6:5]}, 32'h00000004);
      rd_check(ext_v);
      sw_standby <= 1;
      repeat (4) @(posedge hclk);
      pin_check();
      rd_check(ext_v);
      sw_standby <= 0;
      $display("test standby done");
      slave_port_mode_enable <= 1;
      ram <= {8'($random(seed)), 1'b1};
      repeat (4) @(posedge hclk);
      check("ram out", {pin_out, pin_oe_n}, {ram.data, 8'h00});
      ram.oe <= 0;
      repeat (5) @(posedge hclk);
      check("ram in", {24'h0, ram_o}, {24'h0, ext_v});
      check("timer in", {tci_o, tri_o}, {ext_v[3], ext_v[0], ext_v[4], ext_v[1]});
      slave_port_mode_enable <= 0;
      compare_b_output_enable <= 1;
      periph <= 7'h01;
      repeat (2) @(posedge hclk);
      check("top pin", {30'h0, pin_out[7], pin_oe_n[7]}, 32'h00000002);
      compare_b_output_enable <= 0;
      hw_standby <= 1;
      repeat (2) @(posedge hclk);
      hw_standby <= 0;
      expanded_mode <= 0;
      dir_m = DIR_RESET;
      data_m = DATA_RESET;
      repeat (4) @(posedge hclk);
      pin_check();
      rd_check(ext_v);
      $display("test shared done");
      give_verdict();
   end
endmodule : mxio_port_test
`default_nettype wire
